// >>> rtl/rpmc_top.sv
// reset sequencing, reset cause/vector and power-mode control
`default_nettype none

// Functional notes
// - hold reset until supply good, start power and oscillators, init registers, fetch at 0x8000
// - power-on startup waits 14 slow oscillator periods before execution
// - watchdog reset runs the same sequence with a 12 slow period startup
// - cause bit 0 reads 0 after power-on, 1 after any other reset
// - software may set cause bit 1 to force a reload by the boot loader; a watchdog reset here writes cause 01, so it restarts at 0x0000
// - cause bit 1 selects reset vector 0x0000 or boot rom at 0x8000
// - cause register resets to 02; watchdog restarts loaded program at 0
// - idle bit suspends the cpu after the instruction completes, clock keeps running
// - enabled interrupt clears idle bit in hardware and resumes processing
// - watchdog reset leaves idle, stop or power-down and runs the reset sequence
// - stop bit enters stop mode, left only by watchdog reset
// - clock-halt bit suspends cpu and shuts crystal and regulators down
// - power-down ends on external irq, rtc wakeup or watchdog; irq clears halt
// - wake times: 14+24, 12+24, 3+52 and 3+52 slow plus crystal periods
// - busy flag reads as bit 4 of the slow interface control register

module rpmc_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic supply_ok,
    input wire logic wdog_rst,
    input wire logic slow_tick,
    input wire logic instr_done,
    input wire logic irq_taken,
    input wire logic ext_irq,
    input wire logic rtc_wake,
    input wire logic slow_busy,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic cpu_rst,
    output logic cpu_hold,
    output logic [15:0] reset_vector,
    output logic xtal_osc_en,
    output logic regulator_en,
    output logic slow_osc_en,
    output logic [7:0] power_control_register,
    output logic [1:0] reset_cause_register
);
    import rpmc_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        rpmc_state_type st;
        logic [7:0] pwr;
        logic [1:0] cause;
        logic clk_halt;
        logic [7:0] rdata;
        logic cpu_rst;
        logic cpu_hold;
        logic xtal_en;
        logic reg_en;
        logic [15:0] vector;
        logic [SLOW_W-1:0] slow_target;
        logic [XTAL_W-1:0] xtal_target;
        logic tmr_start;
    } rpmc_top_type;

    rpmc_top_type q;
    rpmc_top_type n;
    logic tmr_slow_phase;
    logic tmr_busy;
    logic tmr_done;

    function automatic logic [15:0] pick_vector(input logic [1:0] cause);
        pick_vector = cause[CAUSE_BOOT_ROM_BIT] ? VEC_BOOT : VEC_APP;
    endfunction : pick_vector

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        n = q;
        n.tmr_start = 1'b0;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_POWER_CONTROL: n.rdata = q.pwr;
                ADDR_RESET_CAUSE: n.rdata = {6'h00, q.cause};
                ADDR_CLOCK_CONTROL: n.rdata = {6'h00, q.clk_halt, 1'b0};
                // only the busy flag is ours; the other bits read zero here
                ADDR_SLOW_IF_CONTROL: n.rdata = 8'(slow_busy) << SLOW_BUSY_BIT;
                default: n.rdata = 8'h00;
            endcase
        end
        case (q.st)
            ST_HOLD: begin
                if (supply_ok) begin
                    n.reg_en = 1'b1;
                    n.xtal_en = 1'b1;
                    n.slow_target = SLOW_POR;
                    n.xtal_target = XTAL_POR;
                    n.tmr_start = 1'b1;
                    n.st = ST_START;
                end
            end
            ST_START, ST_WAKE: begin
                // a done left over from a cut startup lands while the restart is loading
                if (tmr_done && !q.tmr_start) begin
                    n.cpu_rst = 1'b0;
                    n.cpu_hold = 1'b0;
                    n.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // entry waits for the instruction that set the bit to finish
                if (instr_done && q.pwr[PWR_IDLE_BIT]) begin
                    n.cpu_hold = 1'b1;
                    n.st = ST_IDLE;
                end else if (instr_done && q.pwr[PWR_STOP_BIT]) begin
                    n.cpu_hold = 1'b1;
                    n.st = ST_STOP;
                end else if (instr_done && q.clk_halt) begin
                    n.cpu_hold = 1'b1;
                    n.xtal_en = 1'b0;
                    n.reg_en = 1'b0;
                    n.st = ST_PDOWN;
                end
            end
            ST_IDLE: begin
                if (irq_taken) begin
                    n.pwr[PWR_IDLE_BIT] = 1'b0;
                    n.cpu_hold = 1'b0;
                    n.st = ST_RUN;
                end
            end
            ST_STOP: begin
                n.st = ST_STOP;
            end
            ST_PDOWN: begin
                if (ext_irq || rtc_wake) begin
                    n.clk_halt = 1'b0;
                    n.xtal_en = 1'b1;
                    n.reg_en = 1'b1;
                    n.slow_target = ext_irq ? SLOW_EXT : SLOW_RTC;
                    n.xtal_target = XTAL_INT;
                    n.tmr_start = 1'b1;
                    n.st = ST_WAKE;
                end
            end
            default: n.st = ST_HOLD;
        endcase
        // a software write lands only in the run state, where no hardware clear occurs; a watchdog or supply reset in the same cycle overrides it
        if (sfr_wr && (q.st == ST_RUN)) begin
            case (sfr_addr)
                ADDR_POWER_CONTROL: n.pwr = sfr_wdata & PWR_WRITE_MASK;
                ADDR_RESET_CAUSE: n.cause = sfr_wdata[1:0];
                ADDR_CLOCK_CONTROL: n.clk_halt = sfr_wdata[CLK_HALT_BIT];
                default: n.clk_halt = n.clk_halt;
            endcase
        end
        if (!supply_ok) begin
            n.st = ST_HOLD;
            n.pwr = PWR_RESET;
            n.cause = CAUSE_RESET;
            n.clk_halt = CLK_HALT_RESET;
            n.cpu_rst = 1'b1;
            n.cpu_hold = 1'b1;
            n.xtal_en = 1'b0;
            n.reg_en = 1'b0;
            n.tmr_start = 1'b0;
        end else if (wdog_rst && (q.st != ST_HOLD)) begin
            n.st = ST_START;
            n.pwr = PWR_RESET;
            n.cause = CAUSE_AFTER_WDOG;
            n.clk_halt = CLK_HALT_RESET;
            n.cpu_rst = 1'b1;
            n.cpu_hold = 1'b1;
            n.xtal_en = 1'b1;
            n.reg_en = 1'b1;
            n.slow_target = SLOW_WDOG;
            n.xtal_target = XTAL_WDOG;
            n.tmr_start = 1'b1;
        end
        n.vector = pick_vector(n.cause);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q.st <= ST_HOLD;
            q.pwr <= PWR_RESET;
            q.cause <= CAUSE_RESET;
            q.clk_halt <= CLK_HALT_RESET;
            q.rdata <= 8'h00;
            q.cpu_rst <= 1'b1;
            q.cpu_hold <= 1'b1;
            q.xtal_en <= 1'b0;
            q.reg_en <= 1'b0;
            q.vector <= VEC_BOOT;
            q.slow_target <= SLOW_POR;
            q.xtal_target <= XTAL_POR;
            q.tmr_start <= 1'b0;
        end else begin
            q <= n;
        end
    end

    rpmc_startup_timer #(
        .SLOW_W(SLOW_W),
        .XTAL_W(XTAL_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(q.tmr_start),
        .slow_cycles(q.slow_target),
        .xtal_cycles(q.xtal_target),
        .slow_tick(slow_tick),
        .slow_phase(tmr_slow_phase),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    assign sfr_rdata = q.rdata;
    assign cpu_rst = q.cpu_rst;
    assign cpu_hold = q.cpu_hold;
    assign reset_vector = q.vector;
    assign xtal_osc_en = q.xtal_en;
    assign regulator_en = q.reg_en;
    // the watchdog and rtc live on this oscillator, so it never stops
    assign slow_osc_en = arst_n | ~arst_n;
    assign power_control_register = q.pwr;
    assign reset_cause_register = q.cause;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [SLOW_W:0] slow_seen;
    logic [XTAL_W:0] xtal_seen;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_seen <= '0;
            xtal_seen <= '0;
        end else if (q.tmr_start) begin
            slow_seen <= '0;
            xtal_seen <= '0;
        end else begin
            if (tmr_slow_phase && slow_tick) begin
                slow_seen <= slow_seen + (SLOW_W+1)'(1);
            end
            if (tmr_busy && !tmr_slow_phase) begin
                xtal_seen <= xtal_seen + (XTAL_W+1)'(1);
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_wdog_hit;
        wdog_rst && supply_ok && (q.st != ST_HOLD);
    endsequence

    sequence s_restart;
        cpu_rst && (q.st == ST_START) && (q.cause == CAUSE_AFTER_WDOG);
    endsequence

    a_supply_hold: assert property (!supply_ok |=> cpu_rst && !regulator_en)
        else $error("reset not held while supply low");
    a_slow_count: assert property ($fell(tmr_slow_phase) && !q.tmr_start
            |-> slow_seen == {1'b0, q.slow_target})
        else $error("slow startup count wrong");
    a_xtal_count: assert property (tmr_done |-> xtal_seen == {1'b0, q.xtal_target})
        else $error("crystal startup count wrong");
    a_por_target: assert property ((q.st == ST_HOLD) && supply_ok
            |=> q.tmr_start && q.slow_target == SLOW_POR && q.xtal_target == XTAL_POR)
        else $error("power-on startup length wrong");
    a_wdog_restart: assert property (s_wdog_hit |=> s_restart ##0
            (q.slow_target == SLOW_WDOG) && !q.cause[CAUSE_BOOT_ROM_BIT])
        else $error("watchdog reset sequence wrong");
    a_vector_select: assert property ($fell(cpu_rst) && $past(q.cause) == CAUSE_RESET
            |-> reset_vector == VEC_BOOT)
        else $error("power-on reset did not vector to boot rom");
    a_mode_wdog_exit: assert property ((q.st inside {ST_IDLE, ST_STOP, ST_PDOWN})
            and s_wdog_hit |=> cpu_rst && regulator_en && xtal_osc_en)
        else $error("watchdog did not leave low-power mode");
    a_stop_sticky: assert property ((q.st == ST_STOP) && !wdog_rst && supply_ok
            |=> q.st == ST_STOP && cpu_hold)
        else $error("stop mode left without watchdog");
    a_idle_enter: assert property ((q.st == ST_RUN) && instr_done
            && q.pwr[PWR_IDLE_BIT] && !wdog_rst && supply_ok |=> cpu_hold && xtal_osc_en)
        else $error("idle entry wrong");
    a_idle_wake: assert property ((q.st == ST_IDLE) && irq_taken
            && !wdog_rst && supply_ok |=> !cpu_hold && !power_control_register[PWR_IDLE_BIT])
        else $error("interrupt did not end idle");
    a_pdown_power: assert property ((q.st == ST_PDOWN)
            |-> !xtal_osc_en && !regulator_en && slow_osc_en)
        else $error("power-down left clocks running");
    a_pdown_wake: assert property ((q.st == ST_PDOWN) && (ext_irq || rtc_wake)
            && !wdog_rst && supply_ok |=> regulator_en && !q.clk_halt
            && q.xtal_target == XTAL_INT)
        else $error("power-down wake wrong");
    a_busy_read: assert property (sfr_rd && sfr_addr == ADDR_SLOW_IF_CONTROL
            |=> sfr_rdata[SLOW_BUSY_BIT] == $past(slow_busy))
        else $error("busy flag readback wrong");

endmodule : rpmc_top

`default_nettype wire

// >>> shared/rpmc_pkg.sv
// constants and types for the reset and power-mode controller
`default_nettype none

package rpmc_pkg;

    // ****************************************************************
    // special function register addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'hb1;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hb6;
    localparam logic [7:0] ADDR_SLOW_IF_CONTROL = 8'had;

    // ****************************************************************
    // field positions and masks
    // ****************************************************************
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam logic [7:0] PWR_WRITE_MASK = 8'h8f;
    localparam int CAUSE_OTHER_BIT = 0;
    localparam int CAUSE_BOOT_ROM_BIT = 1;
    localparam int CLK_HALT_BIT = 1;
    localparam int SLOW_BUSY_BIT = 4;

    // ****************************************************************
    // reset values and vectors
    // ****************************************************************
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic [1:0] CAUSE_RESET = 2'h2;
    localparam logic [1:0] CAUSE_AFTER_WDOG = 2'h1;
    localparam logic CLK_HALT_RESET = 1'b0;
    localparam logic [15:0] VEC_APP = 16'h0000;
    localparam logic [15:0] VEC_BOOT = 16'h8000;

    // ****************************************************************
    // startup counts: slow oscillator periods, then crystal periods
    // ****************************************************************
    localparam int SLOW_W = 4;
    localparam int XTAL_W = 6;
    localparam logic [3:0] SLOW_POR = 4'he;
    localparam logic [3:0] SLOW_WDOG = 4'hc;
    localparam logic [3:0] SLOW_EXT = 4'h3;
    localparam logic [3:0] SLOW_RTC = 4'h3;
    localparam logic [5:0] XTAL_POR = 6'h18;
    localparam logic [5:0] XTAL_WDOG = 6'h18;
    localparam logic [5:0] XTAL_INT = 6'h34;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_START,
        ST_RUN,
        ST_IDLE,
        ST_STOP,
        ST_PDOWN,
        ST_WAKE
    } rpmc_state_type;

endpackage : rpmc_pkg

`default_nettype wire

// >>> rtl/rpmc_startup_timer.sv
// startup timer: counts slow oscillator ticks, then crystal cycles
`default_nettype none

module rpmc_startup_timer #(
    parameter int SLOW_W = 4,
    parameter int XTAL_W = 6
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [SLOW_W-1:0] slow_cycles,
    input wire logic [XTAL_W-1:0] xtal_cycles,
    input wire logic slow_tick,
    output logic slow_phase,
    output logic busy,
    output logic done
);
    import rpmc_pkg::*;

    typedef struct packed {
        logic [SLOW_W-1:0] slow;
        logic [XTAL_W-1:0] xtal;
        logic phase;
        logic busy;
        logic done;
    } rpmc_tmr_type;

    rpmc_tmr_type q;
    rpmc_tmr_type n;

    always_comb begin
        n = q;
        n.done = 1'b0;
        if (start) begin
            n.slow = slow_cycles;
            n.xtal = xtal_cycles;
            n.phase = (slow_cycles != '0);
            n.busy = 1'b1;
        end else if (q.busy && q.phase) begin
            if (slow_tick) begin
                if (q.slow <= SLOW_W'(1)) begin
                    n.phase = 1'b0;
                    n.slow = '0;
                end else begin
                    n.slow = q.slow - SLOW_W'(1);
                end
            end
        end else if (q.busy) begin
            // crystal phase: one cycle per count, done after the last
            if (q.xtal <= XTAL_W'(1)) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.xtal = q.xtal - XTAL_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign slow_phase = q.phase & q.busy;
    assign busy = q.busy;
    assign done = q.done;

endmodule : rpmc_startup_timer

`default_nettype wire

// >>> testbench/rpmc_cpu_model.sv
// cpu and software model driving the special function register bus
`default_nettype none

module rpmc_cpu_model
    import rpmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    output logic instr_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] radio_ctrl;

    initial begin
        radio_ctrl = 8'h80;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        instr_done = 1'b0;
    end

    // released address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk) #1;
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk) #1;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        d = sfr_rdata;
    endtask : rd

    task automatic step();
        @(posedge sys_clk) #1;
        instr_done = 1'b1;
        @(posedge sys_clk) #1;
        instr_done = 1'b0;
    endtask : step

    // the slow interface may still be busy, so poll before touching clock control
    task automatic halt();
        logic [7:0] s;
        radio_ctrl[7] = 1'b0;
        s = 8'hff;
        for (int i = 0; i < 200 && s[SLOW_BUSY_BIT] !== 1'b0; i++) begin
            rd(ADDR_SLOW_IF_CONTROL, s);
        end
        wr(ADDR_CLOCK_CONTROL, 8'h02);
        step();
    endtask : halt
endmodule : rpmc_cpu_model

`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the reset and power-mode controller
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import rpmc_pkg::*;

    logic sys_clk, arst_n, supply_ok, wdog_rst, slow_tick, irq_taken, ext_irq, rtc_wake;
    logic slow_busy, sfr_wr, sfr_rd, instr_done, cpu_rst, cpu_hold;
    logic xtal_osc_en, regulator_en, slow_osc_en;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, power_control_register;
    logic [15:0] reset_vector;
    logic [1:0] reset_cause_register;
    logic [1:0] tick_div = 2'h0;
    logic [31:0] seed = 32'hdb8d226f;
    int err_count, total_checks, cycles;

    rpmc_top u_rpmc_top (.sys_clk(sys_clk), .arst_n(arst_n), .supply_ok(supply_ok),
        .wdog_rst(wdog_rst), .slow_tick(slow_tick), .instr_done(instr_done),
        .irq_taken(irq_taken), .ext_irq(ext_irq), .rtc_wake(rtc_wake),
        .slow_busy(slow_busy), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_rst(cpu_rst),
        .cpu_hold(cpu_hold), .reset_vector(reset_vector), .xtal_osc_en(xtal_osc_en),
        .regulator_en(regulator_en), .slow_osc_en(slow_osc_en),
        .power_control_register(power_control_register),
        .reset_cause_register(reset_cause_register));

    rpmc_cpu_model u_rpmc_cpu_model (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .instr_done(instr_done));

    // ****************************************************************
    // clock, slow oscillator tick every 4 cycles, timeout
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        tick_div <= tick_div + 2'h1;
        slow_tick <= #1 (tick_div == 2'h3);
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            conclude();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk_val

    task automatic chk_rng(input string n, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", n, lo, hi, g);
        end
    endtask : chk_rng

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_rpmc_cpu_model.rd(a, d);
        chk_val(n, {8'h00, e}, {8'h00, d});
    endtask : rd_chk

    task automatic wait_hold(input logic v, output int n);
        n = 0;
        while (cpu_hold !== v && n < 1000) begin
            @(posedge sys_clk) #1;
            n++;
        end
    endtask : wait_hold

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk) #1;
    endtask : cyc

    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] d;
        int n;
        arst_n = 1'b0;
        supply_ok = 1'b1;
        wdog_rst = 1'b0;
        slow_tick = 1'b0;
        irq_taken = 1'b0;
        ext_irq = 1'b0;
        rtc_wake = 1'b0;
        slow_busy = 1'b0;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        cyc(2);
        chk_val("cause in reset", 16'(CAUSE_RESET), 16'(reset_cause_register));
        chk_val("vector in reset", 16'h8000, reset_vector);
        arst_n = 1'b1;
        wait_hold(1'b0, n);
        chk_rng("power-on startup", 14 * 4 + 20, 14 * 4 + 34, n);
        chk_val("cpu reset released", 16'h0000, 16'(cpu_rst));
        chk_val("regulator on", 16'h0001, 16'(regulator_en));
        rd_chk("cause after power-on", ADDR_RESET_CAUSE, 8'h02);
        rd_chk("unmapped read", 8'h00, 8'h00);
        seed = lfsr(seed);
        d = seed[7:0] & 8'hfc;
        u_rpmc_cpu_model.wr(ADDR_POWER_CONTROL, d);
        rd_chk("power control", ADDR_POWER_CONTROL, d & 8'h8f);
        for (int v = 0; v < 4; v++) begin
            u_rpmc_cpu_model.wr(ADDR_RESET_CAUSE, 8'(v));
            rd_chk("cause write", ADDR_RESET_CAUSE, 8'(v));
            chk_val("vector", (v >= 2) ? 16'h8000 : 16'h0000, reset_vector);
        end
        slow_busy = 1'b1;
        rd_chk("busy flag", ADDR_SLOW_IF_CONTROL, 8'h10);
        slow_busy = 1'b0;
        // idle: left by a taken interrupt, hold stands until then
        u_rpmc_cpu_model.wr(ADDR_POWER_CONTROL, 8'h01);
        u_rpmc_cpu_model.step();
        seed = lfsr(seed);
        cyc(1 + 32'(seed[2:0]));
        chk_val("idle hold", 16'h0001, 16'(cpu_hold));
        chk_val("idle clock", 16'h0001, 16'(xtal_osc_en));
        // a write while suspended must not disturb the retained registers
        u_rpmc_cpu_model.wr(ADDR_RESET_CAUSE, 8'h00);
        chk_val("idle retains cause", 16'h0003, 16'(reset_cause_register));
        irq_taken = 1'b1;
        cyc(1);
        irq_taken = 1'b0;
        wait_hold(1'b0, n);
        chk_rng("idle exit", 0, 2, n);
        chk_val("idle bit cleared", 16'h0000, 16'(power_control_register[0]));
        // stop: interrupts ignored, only the watchdog ends it
        u_rpmc_cpu_model.wr(ADDR_POWER_CONTROL, 8'h02);
        u_rpmc_cpu_model.step();
        irq_taken = 1'b1;
        ext_irq = 1'b1;
        cyc(3);
        irq_taken = 1'b0;
        ext_irq = 1'b0;
        cyc(4);
        chk_val("stop hold", 16'h0001, 16'(cpu_hold));
        wdog_rst = 1'b1;
        cyc(1);
        wdog_rst = 1'b0;
        chk_val("watchdog cpu reset", 16'h0001, 16'(cpu_rst));
        chk_val("watchdog cause", 16'h0001, 16'(reset_cause_register));
        chk_val("watchdog vector", 16'h0000, reset_vector);
        chk_val("watchdog power control", 16'h0000, 16'(power_control_register));
        wait_hold(1'b0, n);
        chk_rng("watchdog startup", 12 * 4 + 20, 12 * 4 + 34, n);
        // power-down, woken by the external interrupt then by the rtc
        for (int src = 0; src < 2; src++) begin
            slow_busy = 1'b1;
            fork
                begin
                    cyc(20);
                    slow_busy = 1'b0;
                end
            join_none
            u_rpmc_cpu_model.halt();
            cyc(2);
            chk_val("crystal off", 16'h0000, 16'(xtal_osc_en));
            chk_val("regulator off", 16'h0000, 16'(regulator_en));
            chk_val("slow osc on", 16'h0001, 16'(slow_osc_en));
            seed = lfsr(seed);
            cyc(2 + 32'(seed[3:0]));
            chk_val("power-down hold", 16'h0001, 16'(cpu_hold));
            ext_irq = (src == 0);
            rtc_wake = (src == 1);
            wait_hold(1'b0, n);
            ext_irq = 1'b0;
            rtc_wake = 1'b0;
            chk_rng("wake time", 3 * 4 + 48, 4 * 4 + 62, n);
            chk_val("crystal on", 16'h0001, 16'(xtal_osc_en));
            chk_val("regulator on after wake", 16'h0001, 16'(regulator_en));
            rd_chk("halt bit cleared", ADDR_CLOCK_CONTROL, 8'h00);
        end
        // supply drop returns to the power-on state
        supply_ok = 1'b0;
        cyc(2);
        chk_val("supply low reset", 16'h0001, 16'(cpu_rst));
        chk_val("supply low cause", 16'h0002, 16'(reset_cause_register));
        supply_ok = 1'b1;
        wait_hold(1'b0, n);
        chk_rng("second power-on", 14 * 4 + 20, 14 * 4 + 34, n);
        conclude();
    end
endmodule : testbench

`default_nettype wire
